// ==== inc/bm_addr_regs.svh ====
`ifndef BM_ADDR_REGS_SVH
`define BM_ADDR_REGS_SVH

// register byte offsets on the AXI4-Lite slave
`define WR_START_OFS 8'h00
`define WR_END_OFS 8'h04
`define WR_BUF_PROG_OFS 8'h08
`define WR_BUS_PROG_OFS 8'h0C
`define RD_START_OFS 8'h10
`define RD_END_OFS 8'h14
`define CTRL_OFS 8'h18
`define STATUS_OFS 8'h1C

// control register fields
`define CTRL_WR_GO_BIT 0
`define CTRL_RD_GO_BIT 1
`define CTRL_WR_ABORT_BIT 2
`define CTRL_RD_ABORT_BIT 3

// status register fields
`define STAT_WR_BUSY_BIT 0
`define STAT_RD_BUSY_BIT 1
`define STAT_WR_ERR_BIT 2

// reset value and address step
`define ADDR_RST 32'hFFFFFFFF
`define WORD_STEP 32'h00000004

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== inc/bm_addr_pkg.sv ====
package bm_addr_pkg;

    // one register-bus write: write-address beat plus write-data beat and strobes
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } reg_write_type;

    // bus-side master write beat toward the target
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } bus_beat_type;

    // per-direction transfer state
    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_RUN = 2'b01,
        XFER_DONE = 2'b10
    } xfer_state_type;

endpackage

// ==== rtl/bm_addr_stepper.sv ====
`timescale 1ns/1ns
`include "bm_addr_regs.svh"

// incrementing address walker for one direction
module bm_addr_stepper
    import bm_addr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [31:0] start_addr_i,
    input wire logic [31:0] end_addr_i,
    input wire logic step_i,
    output logic [31:0] addr_o,
    output logic busy_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    xfer_state_type state_q; // walker state
    xfer_state_type state_d;
    logic [31:0] addr_q; // current address
    logic [31:0] addr_d;
    wire logic [31:0] next_addr; // address after this step
    wire logic last_step; // step passes the end address

    assign next_addr = addr_q + `WORD_STEP;
    assign last_step = step_i && (next_addr > end_addr_i
        || next_addr < addr_q);
    assign busy_o = (state_q == XFER_RUN);
    assign addr_o = addr_q;

    // next-state: only upward steps; a step that wraps past all ones is still taken and ends the run
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        unique case (state_q)
            XFER_IDLE, XFER_DONE: begin
                if (start_i) begin
                    state_d = XFER_RUN;
                    addr_d = start_addr_i;
                end
            end
            XFER_RUN: begin
                if (abort_i) begin
                    // address left as is for software to inspect
                    state_d = XFER_DONE;
                end else if (step_i) begin
                    addr_d = next_addr;
                    if (last_step) begin
                        state_d = XFER_DONE;
                    end
                end
            end
            default: begin
                state_d = XFER_IDLE;
            end
        endcase
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= XFER_IDLE;
            addr_q <= `ADDR_RST;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
        end
    end

endmodule // bm_addr_stepper

// ==== rtl/bm_addr_tracker.sv ====
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "bm_addr_regs.svh"

module bm_addr_tracker
    import bm_addr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic [7:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [7:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    // endpoint side of master write
    input wire logic [31:0] ep_data_i,
    input wire logic ep_valid_i,
    output logic ep_ready_o,
    // bus side of master write
    output logic [31:0] mw_addr_o,
    output logic [31:0] mw_data_o,
    output logic mw_valid_o,
    input wire logic mw_ready_i,
    input wire logic mw_error_i,
    // master read bus address and beat taken
    output logic [31:0] mr_addr_o,
    output logic mr_valid_o,
    input wire logic mr_ready_i,
    output logic wr_busy_o,
    output logic rd_busy_o
);

    // ------------------------------------------------
    // register bus slave
    // ------------------------------------------------
    logic aw_held_q; // write address captured
    logic w_held_q; // write data captured
    reg_write_type wr_q; // captured write beat
    logic bvalid_q; // write response pending
    logic [1:0] bresp_q;
    logic rvalid_q; // read data pending
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    wire logic aw_take; // address handshake this edge
    wire logic w_take; // data handshake this edge
    wire logic wr_fire; // both halves held, do the write
    wire logic ar_take; // read address handshake

    assign aw_take = s_awvalid_i && s_awready_o;
    assign w_take = s_wvalid_i && s_wready_o;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign ar_take = s_arvalid_i && s_arready_o;

    // ------------------------------------------------
    // software registers
    // ------------------------------------------------
    logic [31:0] wr_start_q; // write start address
    logic [31:0] wr_end_q; // write end address
    logic [31:0] rd_start_q; // read start address
    logic [31:0] rd_end_q; // read end address
    logic wr_go_q; // one-cycle start pulses
    logic rd_go_q;
    logic wr_abort_q; // one-cycle abort pulses
    logic rd_abort_q;
    logic wr_err_q; // sticky bus error flag
    wire logic [31:0] strb_mask; // byte lanes as bit mask
    wire logic sel_wr_start;
    wire logic sel_wr_end;
    wire logic sel_rd_start;
    wire logic sel_rd_end;
    wire logic sel_ctrl;
    wire logic sel_stat;
    wire logic sel_ro; // read-only progress words
    wire logic wr_mapped;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign strb_mask[gi*8 +: 8] = {8{wr_q.strb[gi]}};
        end
    endgenerate

    assign sel_wr_start = wr_q.addr == `WR_START_OFS;
    assign sel_wr_end = wr_q.addr == `WR_END_OFS;
    assign sel_rd_start = wr_q.addr == `RD_START_OFS;
    assign sel_rd_end = wr_q.addr == `RD_END_OFS;
    assign sel_ctrl = wr_q.addr == `CTRL_OFS;
    assign sel_stat = wr_q.addr == `STATUS_OFS;
    assign sel_ro = wr_q.addr == `WR_BUF_PROG_OFS
        || wr_q.addr == `WR_BUS_PROG_OFS;
    assign wr_mapped = sel_wr_start || sel_wr_end || sel_rd_start
        || sel_rd_end || sel_ctrl || sel_stat || sel_ro;

    // ------------------------------------------------
    // address walkers
    // ------------------------------------------------
    logic [31:0] buf_prog; // endpoint-to-buffer progress
    logic [31:0] bus_prog; // buffer-to-target progress
    logic [31:0] rd_addr; // master read bus address
    logic wr_buf_busy;
    logic wr_bus_busy;
    logic rd_busy;
    logic held_q; // one-word master write buffer full
    logic [31:0] held_data_q; // buffered datum
    wire logic ep_take; // datum moved from endpoint
    wire logic bus_take; // datum delivered to target
    wire logic rd_take; // read beat taken by target

    // buffer only accepts when empty, so nothing is overwritten
    assign ep_take = ep_valid_i && !held_q && wr_buf_busy
        && !wr_abort_q && !mw_error_i;
    assign bus_take = held_q && mw_ready_i && wr_bus_busy;
    assign rd_take = mr_ready_i && rd_busy;

    bm_addr_stepper u_wr_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(wr_go_q),
        .abort_i(wr_abort_q || mw_error_i),
        .start_addr_i(wr_start_q),
        .end_addr_i(wr_end_q),
        .step_i(ep_take),
        .addr_o(buf_prog),
        .busy_o(wr_buf_busy)
    );

    bm_addr_stepper u_wr_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(wr_go_q),
        .abort_i(wr_abort_q || mw_error_i),
        .start_addr_i(wr_start_q),
        .end_addr_i(wr_end_q),
        .step_i(bus_take),
        .addr_o(bus_prog),
        .busy_o(wr_bus_busy)
    );

    bm_addr_stepper u_rd (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(rd_go_q),
        .abort_i(rd_abort_q),
        .start_addr_i(rd_start_q),
        .end_addr_i(rd_end_q),
        .step_i(rd_take),
        .addr_o(rd_addr),
        .busy_o(rd_busy)
    );

    // read data mux
    wire logic [31:0] rd_word;
    wire logic rd_mapped;
    assign rd_mapped = s_araddr_i == `WR_START_OFS
        || s_araddr_i == `WR_END_OFS || s_araddr_i == `WR_BUF_PROG_OFS
        || s_araddr_i == `WR_BUS_PROG_OFS || s_araddr_i == `RD_START_OFS
        || s_araddr_i == `RD_END_OFS || s_araddr_i == `CTRL_OFS
        || s_araddr_i == `STATUS_OFS;
    assign rd_word =
        (s_araddr_i == `WR_START_OFS) ? wr_start_q :
        (s_araddr_i == `WR_END_OFS) ? wr_end_q :
        (s_araddr_i == `WR_BUF_PROG_OFS) ? buf_prog :
        (s_araddr_i == `WR_BUS_PROG_OFS) ? bus_prog :
        (s_araddr_i == `RD_START_OFS) ? rd_start_q :
        (s_araddr_i == `RD_END_OFS) ? rd_end_q :
        (s_araddr_i == `STATUS_OFS) ?
            {29'h0, wr_err_q, rd_busy, wr_buf_busy || wr_bus_busy} :
        32'h00000000;

    // bus slave handshakes; response follows both halves
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wr_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                wr_q.addr <= s_awaddr_i;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wr_q.data <= s_wdata_i;
                wr_q.strb <= s_wstrb_i;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                // unmapped or read-only words answer slverr
                bresp_q <= (wr_mapped && !sel_ro) ? `RESP_OKAY
                    : `RESP_SLVERR;
            end else if (bvalid_q && s_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_q && s_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    // software-written address registers and pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_start_q <= `ADDR_RST;
            wr_end_q <= `ADDR_RST;
            rd_start_q <= `ADDR_RST;
            rd_end_q <= `ADDR_RST;
            wr_go_q <= 1'b0;
            rd_go_q <= 1'b0;
            wr_abort_q <= 1'b0;
            rd_abort_q <= 1'b0;
        end else begin
            wr_go_q <= wr_fire && sel_ctrl && wr_q.strb[0]
                && wr_q.data[`CTRL_WR_GO_BIT];
            rd_go_q <= wr_fire && sel_ctrl && wr_q.strb[0]
                && wr_q.data[`CTRL_RD_GO_BIT];
            wr_abort_q <= wr_fire && sel_ctrl && wr_q.strb[0]
                && wr_q.data[`CTRL_WR_ABORT_BIT];
            rd_abort_q <= wr_fire && sel_ctrl && wr_q.strb[0]
                && wr_q.data[`CTRL_RD_ABORT_BIT];
            if (wr_fire && sel_wr_start) begin
                wr_start_q <= (wr_start_q & ~strb_mask)
                    | (wr_q.data & strb_mask);
            end
            if (wr_fire && sel_wr_end) begin
                wr_end_q <= (wr_end_q & ~strb_mask)
                    | (wr_q.data & strb_mask);
            end
            if (wr_fire && sel_rd_start) begin
                rd_start_q <= (rd_start_q & ~strb_mask)
                    | (wr_q.data & strb_mask);
            end
            if (wr_fire && sel_rd_end) begin
                rd_end_q <= (rd_end_q & ~strb_mask)
                    | (wr_q.data & strb_mask);
            end
        end
    end

    // sticky error: a new error beats a clearing write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_err_q <= 1'b0;
        end else if (mw_error_i && wr_bus_busy) begin
            wr_err_q <= 1'b1;
        end else if (wr_fire && sel_stat && wr_q.strb[0]
            && wr_q.data[`STAT_WR_ERR_BIT]) begin
            wr_err_q <= 1'b0;
        end
    end

    // one-word master write buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held_q <= 1'b0;
            held_data_q <= 32'h00000000;
        end else if (ep_take) begin
            held_q <= 1'b1;
            held_data_q <= ep_data_i;
        end else if (bus_take || !wr_bus_busy) begin
            held_q <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ep_ready_o <= 1'b0;
            mw_valid_o <= 1'b0;
            mw_addr_o <= `ADDR_RST;
            mw_data_o <= 32'h00000000;
            mr_valid_o <= 1'b0;
            mr_addr_o <= `ADDR_RST;
            wr_busy_o <= 1'b0;
            rd_busy_o <= 1'b0;
        end else begin
            ep_ready_o <= wr_buf_busy && !held_q && !ep_take;
            // no write beat issued once the walker has stopped; mr_valid_o follows rd_busy one cycle late
            // a stopped write transfer shows no beat, not even one cycle late
            mw_valid_o <= (wr_bus_busy && held_q && !bus_take
                && !wr_abort_q && !mw_error_i) || ep_take;
            mw_addr_o <= bus_take ? bus_prog + `WORD_STEP : bus_prog;
            mw_data_o <= ep_take ? ep_data_i : held_data_q;
            mr_valid_o <= rd_busy;
            mr_addr_o <= rd_addr;
            wr_busy_o <= wr_buf_busy || wr_bus_busy;
            rd_busy_o <= rd_busy;
        end
    end

    assign s_awready_o = !aw_held_q && !bvalid_q;
    assign s_wready_o = !w_held_q && !bvalid_q;
    assign s_bvalid_o = bvalid_q;
    assign s_bresp_o = bresp_q;
    assign s_arready_o = !rvalid_q;
    assign s_rvalid_o = rvalid_q;
    assign s_rdata_o = rdata_q;
    assign s_rresp_o = rresp_q;

endmodule // bm_addr_tracker

// ==== tb/bm_addr_tracker_props.sv ====
`timescale 1ns/1ns
`include "bm_addr_regs.svh"
// ----------------------------
// protocol and address checks
// ----------------------------
module bm_addr_tracker_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    input wire logic s_awready_o,
    input wire logic [1:0] s_bresp_o,
    input wire logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic s_rvalid_o,
    input wire logic s_rready_i,
    input wire logic [31:0] mw_addr_o,
    input wire logic [31:0] mw_data_o,
    input wire logic mw_valid_o,
    input wire logic mw_ready_i,
    input wire logic mw_error_i,
    input wire logic [31:0] mr_addr_o,
    input wire logic mr_valid_o,
    input wire logic mr_ready_i,
    input wire logic wr_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [7:0] aw_q; // address of the write in flight
    logic [31:0] nxt_q; // where the next beat must land
    logic seen_q; // a beat of this transfer already left

    // shadow of slave and walker, tiny on purpose
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_q <= 8'h00;
            nxt_q <= 32'h00000000;
            seen_q <= 1'h0;
        end else begin
            if (s_awvalid_i && s_awready_o) aw_q <= s_awaddr_i;
            if (mw_valid_o && mw_ready_i) nxt_q <= mw_addr_o + 32'h00000004;
            seen_q <= wr_busy_o && (seen_q || (mw_valid_o && mw_ready_i));
        end
    end

    a_bvalid_hold: assert property (
        s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
        else $error("write response dropped early");
    a_rvalid_hold: assert property (
        s_rvalid_o && !s_rready_i |=> s_rvalid_o)
        else $error("read response dropped early");
    a_ro_refused: assert property (
        s_bvalid_o && (aw_q == `WR_BUF_PROG_OFS || aw_q == `WR_BUS_PROG_OFS)
        |-> s_bresp_o == `RESP_SLVERR)
        else $error("progress register write not refused");
    a_beat_hold: assert property (
        mw_valid_o && !mw_ready_i && !mw_error_i
        |=> mw_valid_o && $stable(mw_addr_o) && $stable(mw_data_o))
        else $error("held beat lost or changed");
    a_beat_step: assert property (
        mw_valid_o && seen_q |-> mw_addr_o == nxt_q)
        else $error("write beat address not next word");
    a_read_step: assert property (
        mr_valid_o && mr_ready_i
        |=> !mr_valid_o || mr_addr_o == $past(mr_addr_o) + 32'h00000004)
        else $error("read address not stepping up by a word");
    a_error_stop: assert property (
        mw_error_i && wr_busy_o |-> ##[1:2] !wr_busy_o)
        else $error("write transfer runs on after error");
    a_reset_ones: assert property (
        $past(rst_i) |-> mw_addr_o == `ADDR_RST && mr_addr_o == `ADDR_RST
        && !mw_valid_o)
        else $error("walker not at all ones after reset");

    c_beat: cover property (mw_valid_o && mw_ready_i);
    c_read: cover property (mr_valid_o && mr_ready_i);
    c_error: cover property (mw_error_i && wr_busy_o);
endmodule // bm_addr_tracker_props

bind bm_addr_tracker bm_addr_tracker_props bm_addr_tracker_props_i (.*);

// ==== tb/bm_target_model.sv ====
`timescale 1ns/1ns
// ----------------------------------
// bus target memory, stall and error
// ----------------------------------
module bm_target_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i, // bench asks for back-pressure
    input wire logic fail_i, // bench asks for one error pulse
    input wire logic [31:0] mw_addr_i,
    input wire logic [31:0] mw_data_i,
    input wire logic mw_valid_i,
    output logic mw_ready_o,
    output logic mw_error_o,
    input wire logic [31:0] mr_addr_i,
    input wire logic mr_valid_i,
    output logic mr_ready_o,
    output logic [7:0] mw_count_o, // beats stored so far
    output logic [7:0] mr_count_o, // read addresses served
    output logic [31:0] mw_last_o, // address of last stored beat
    output logic [31:0] mw_word_o, // data of last stored beat
    output logic [31:0] mr_last_o // last read address served
);
    // ready is registered so it moves just after an edge, like real targets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mw_ready_o <= 1'h0;
            mr_ready_o <= 1'h0;
            mw_error_o <= 1'h0;
            mw_count_o <= 8'h00;
            mr_count_o <= 8'h00;
        end else begin
            mw_ready_o <= !stall_i;
            mr_ready_o <= !stall_i;
            mw_error_o <= fail_i;
            // store a beat only on a real handshake
            if (mw_valid_i && mw_ready_o) begin
                mw_count_o <= mw_count_o + 8'h01;
                mw_last_o <= mw_addr_i;
                mw_word_o <= mw_data_i;
            end
            if (mr_valid_i && mr_ready_o) begin
                mr_count_o <= mr_count_o + 8'h01;
                mr_last_o <= mr_addr_i;
            end
        end
    end
endmodule // bm_target_model

// ==== tb/bm_addr_tracker_tb.sv ====
`timescale 1ns/1ns
`include "bm_addr_regs.svh"
// ---------------------------------
// bench: register table, transfers
// ---------------------------------
module bm_addr_tracker_tb
    import bm_addr_pkg::*;
;
    typedef struct packed {
        reg_write_type w; // what software writes
        logic [31:0] rd; // what it must read back
        logic [1:0] wr_resp;
        logic [1:0] rd_resp;
    } row_type;
    localparam logic [1:0] OK = `RESP_OKAY;
    localparam logic [1:0] ER = `RESP_SLVERR;

    logic clk_i, rst_i;
    logic [7:0] s_awaddr_i, s_araddr_i;
    logic [31:0] s_wdata_i, s_rdata_o, ep_data_i, mw_addr_o, mw_data_o;
    logic [31:0] mr_addr_o, mw_last, mw_word, mr_last, rd_val;
    logic [3:0] s_wstrb_i;
    logic [1:0] s_bresp_o, s_rresp_o, rsp;
    logic s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, s_bvalid_o;
    logic s_bready_i, s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i;
    logic ep_valid_i, ep_ready_o, mw_valid_o, mw_ready_i, mw_error_i;
    logic mr_valid_o, mr_ready_i, wr_busy_o, rd_busy_o, stall, fail;
    logic [7:0] mw_cnt, mr_cnt;
    int fails, compares;

    // partial strobe row keeps upper lanes; last row is unmapped
    row_type rows [8] = '{
        '{'{`WR_START_OFS, 32'h00001000, 4'hF}, 32'h00001000, OK, OK},
        '{'{`WR_END_OFS, 32'h0000100C, 4'hF}, 32'h0000100C, OK, OK},
        '{'{`RD_START_OFS, 32'h00002000, 4'hF}, 32'h00002000, OK, OK},
        '{'{`RD_END_OFS, 32'h0000FF08, 4'hF}, 32'h0000FF08, OK, OK},
        '{'{`RD_END_OFS, 32'hAAAA2008, 4'h3}, 32'h00002008, OK, OK},
        '{'{`WR_BUF_PROG_OFS, 32'h12345678, 4'hF}, `ADDR_RST, ER, OK},
        '{'{`WR_BUS_PROG_OFS, 32'h12345678, 4'hF}, `ADDR_RST, ER, OK},
        '{'{8'h40, 32'h00000001, 4'hF}, 32'h00000000, ER, ER}
    };

    bm_addr_tracker bm_addr_tracker_i (.*);
    bm_target_model bm_target_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .fail_i(fail),
        .mw_addr_i(mw_addr_o), .mw_data_i(mw_data_o), .mw_valid_i(mw_valid_o),
        .mw_ready_o(mw_ready_i), .mw_error_o(mw_error_i),
        .mr_addr_i(mr_addr_o), .mr_valid_i(mr_valid_o), .mr_ready_o(mr_ready_i),
        .mw_count_o(mw_cnt), .mr_count_o(mr_cnt), .mw_last_o(mw_last),
        .mw_word_o(mw_word), .mr_last_o(mr_last)
    );

    // 250 MHz clock
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic axw(input reg_write_type w, output logic [1:0] r);
        logic a, d;
        int n;
        a = 1'h1;
        d = 1'h1;
        n = 0;
        @(posedge clk_i);
        s_awaddr_i <= w.addr;
        s_wdata_i <= w.data;
        s_wstrb_i <= w.strb;
        s_awvalid_i <= 1'h1;
        s_wvalid_i <= 1'h1;
        s_bready_i <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
            if (a && s_awready_o === 1'h1) begin
                a = 1'h0;
                s_awvalid_i <= 1'h0;
            end
            if (d && s_wready_o === 1'h1) begin
                d = 1'h0;
                s_wvalid_i <= 1'h0;
            end
        end while ((a || d) && n < 99);
        while (s_bvalid_o !== 1'h1 && n < 99) begin
            @(posedge clk_i);
            n++;
        end
        s_bready_i <= 1'h0;
        if (s_bvalid_o !== 1'h1) fails++;
        r = s_bresp_o;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        s_araddr_i <= a;
        s_arvalid_i <= 1'h1;
        s_rready_i <= 1'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (s_arready_o !== 1'h1 && n < 99);
        s_arvalid_i <= 1'h0;
        while (s_rvalid_o !== 1'h1 && n < 99) begin
            @(posedge clk_i);
            n++;
        end
        s_rready_i <= 1'h0;
        if (s_rvalid_o !== 1'h1) fails++;
        v = s_rdata_o;
        r = s_rresp_o;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a, rd_val, rsp);
        chk(rd_val, e);
    endtask

    // wait for a beat count and all three walkers idle
    task automatic settle(ref logic [7:0] c, input logic [7:0] e);
        int n;
        n = 0;
        do @(posedge clk_i);
        while ((c !== e || wr_busy_o !== 1'h0 || rd_busy_o !== 1'h0)
               && ++n < 500);
        if (n >= 500) fails++;
    endtask

    initial begin
        fails = 0;
        compares = 0;
        rst_i = 1'h1;
        stall = 1'h0;
        fail = 1'h0;
        s_awaddr_i = 8'h00;
        s_araddr_i = 8'h00;
        s_wdata_i = 32'h00000000;
        s_wstrb_i = 4'h0;
        {s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = 5'h00;
        ep_data_i = 32'h5A5AF00D;
        ep_valid_i = 1'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int k = 0; k < 6; k++) rchk(8'(k * 4), `ADDR_RST);
        // ordinary register cases
        foreach (rows[k]) begin
            axw(rows[k].w, rsp);
            chk({30'h0, rsp}, {30'h0, rows[k].wr_resp});
            rd(rows[k].w.addr, rd_val, rsp);
            chk(rd_val, rows[k].rd);
            chk({30'h0, rsp}, {30'h0, rows[k].rd_resp});
        end
        // write transfer with the target stalling first
        stall <= 1'h1;
        ep_valid_i <= 1'h1;
        axw('{`CTRL_OFS, 32'h00000001, 4'hF}, rsp);
        repeat (20) @(posedge clk_i);
        rchk(`WR_BUF_PROG_OFS, 32'h00001004);
        rchk(`WR_BUS_PROG_OFS, 32'h00001000);
        chk({31'h0, ep_ready_o}, 32'h00000000);
        chk({31'h0, wr_busy_o}, 32'h00000001);
        stall <= 1'h0;
        settle(mw_cnt, 8'h04);
        rchk(`WR_BUF_PROG_OFS, 32'h00001010);
        rchk(`WR_BUS_PROG_OFS, 32'h00001010);
        chk(mw_last, 32'h0000100C);
        chk(mw_word, 32'h5A5AF00D);
        chk({24'h0, mw_cnt}, 32'h00000004);
        // error in mid-transfer leaves progress readable
        axw('{`WR_START_OFS, 32'h00003000, 4'hF}, rsp);
        axw('{`WR_END_OFS, 32'h000030FC, 4'hF}, rsp);
        stall <= 1'h1;
        axw('{`CTRL_OFS, 32'h00000001, 4'hF}, rsp);
        repeat (8) @(posedge clk_i);
        fail <= 1'h1;
        @(posedge clk_i);
        fail <= 1'h0;
        settle(mw_cnt, 8'h04);
        rchk(`WR_BUF_PROG_OFS, 32'h00003004);
        rchk(`WR_BUS_PROG_OFS, 32'h00003000);
        rd(`STATUS_OFS, rd_val, rsp);
        chk({31'h0, rd_val[`STAT_WR_ERR_BIT]}, 32'h00000001);
        ep_valid_i <= 1'h0;
        stall <= 1'h0;
        // read walker over three words
        axw('{`CTRL_OFS, 32'h00000002, 4'hF}, rsp);
        settle(mr_cnt, 8'h03);
        chk(mr_last, 32'h00002008);
        rchk(`RD_START_OFS, 32'h00002000);
        chk({24'h0, mr_cnt}, 32'h00000003);
        // read started against a stalled target, then aborted
        stall <= 1'h1;
        axw('{`CTRL_OFS, 32'h00000002, 4'hF}, rsp);
        repeat (2) @(posedge clk_i);
        chk({31'h0, rd_busy_o}, 32'h00000001);
        axw('{`CTRL_OFS, 32'h00000008, 4'hF}, rsp);
        settle(mr_cnt, 8'h03);
        chk({31'h0, rd_busy_o}, 32'h00000000);
        chk({24'h0, mr_cnt}, 32'h00000003);
        // second reset with all walkers idle
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        rchk(`WR_START_OFS, `ADDR_RST);
        conclude();
    end

    // hang guard, well past the expected run
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        conclude();
    end
endmodule // bm_addr_tracker_tb
